// ### rtl/epv_pkg.sv
// Package of constants and types shared by both ends of the EPROM program/verify port
package epv_pkg;
   localparam int ADDR_W = 13;
   localparam int DATA_W = 8;
   localparam int MEM_DEPTH = 8192;
   localparam int KEY_DEPTH = 32;
   localparam int KEY_W = 5;
   localparam int CLK_MHZ = 20;
   localparam int PULSE_COUNT = 25;
   localparam logic [4:0] PULSE_COUNT_M1 = 5'h18;
   // Program pulse low time 100 us nominal, high time at least 10 us
   localparam int PULSE_LOW_US = 100;
   localparam int PULSE_HIGH_US = 10;
   localparam int PULSE_LOW_CYC = PULSE_LOW_US * CLK_MHZ;
   localparam int PULSE_HIGH_CYC = PULSE_HIGH_US * CLK_MHZ;
   // Setup/hold between pin changes and strobe, 48 oscillator periods at the 6 MHz top rate
   localparam int SETUP_CYC = 48 * CLK_MHZ / 6 + 1;
   localparam logic [12:0] SIG_MAKER_ADDR = 13'h0030;
   localparam logic [12:0] SIG_PART_ADDR = 13'h0031;
   // Identification values are arbitrary
   localparam logic [7:0] SIG_MAKER_VAL = 8'hA5;
   localparam logic [7:0] SIG_PART_VAL = 8'h5A;
   localparam logic [7:0] ERASED_BYTE = 8'hFF;
   typedef enum logic [2:0] {
      EPV_OP_VERIFY,
      EPV_OP_SIGNATURE,
      EPV_OP_PROG_CODE,
      EPV_OP_PROG_KEY,
      EPV_OP_PROG_SEC1,
      EPV_OP_PROG_SEC2
   } epv_op_t;
endpackage : epv_pkg

// ### rtl/epv_if.sv
// Pin-level interface between the programming system and the device port
`timescale 1ns/1ps
interface epv_if;
   logic rst_n;
   logic program_store_enable_n;
   logic latch_strobe_program_pulse_n;
   logic external_access_prog_supply;
   logic prog_supply_high;
   logic port2_bit7_enable;
   logic port2_bit6_select;
   logic port3_bit7_select;
   logic port3_bit6_select;
   logic [12:0] addr;
   logic [7:0] p0_host_out;
   logic p0_host_oe;
   logic [7:0] p0_dev_out;
   logic p0_dev_oe;
   logic [7:0] p0_in;
   assign p0_in = p0_dev_oe ? p0_dev_out : (p0_host_oe ? p0_host_out : 8'hFF);
   modport host (
      output rst_n, program_store_enable_n, latch_strobe_program_pulse_n,
      output external_access_prog_supply, prog_supply_high,
      output port2_bit7_enable, port2_bit6_select, port3_bit7_select, port3_bit6_select,
      output addr, p0_host_out, p0_host_oe,
      input p0_in
   );
   modport dev (
      input rst_n, program_store_enable_n, latch_strobe_program_pulse_n,
      input external_access_prog_supply, prog_supply_high,
      input port2_bit7_enable, port2_bit6_select, port3_bit7_select, port3_bit6_select,
      input addr, p0_in,
      output p0_dev_out, p0_dev_oe
   );
endinterface : epv_if

// ### rtl/epv_device.sv
// Device end: on-chip EPROM array with program, verify, signature and security logic
`timescale 1ns/1ps
module epv_device (
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   // Pins
   epv_if.dev pins,
   // Status
   output logic o_sec1_ff,
   output logic o_sec2_ff,
   output logic o_key_set_ff,
   output logic o_prog_mode_ff
);
   logic [7:0] mem [0:epv_pkg::MEM_DEPTH-1];
   logic [7:0] key [0:epv_pkg::KEY_DEPTH-1];
   logic [12:0] s1_addr, s2_addr;
   logic [7:0] s1_d, s2_d;
   logic [8:0] s1_c, s2_c;
   logic strb_d_ff;
   logic [7:0] dout_ff;
   logic oe_ff;
   wire program_store_enable_n_n = s2_c[0];
   wire rst_pin_n = s2_c[1];
   wire strobe_n = s2_c[2];
   wire ea_hi = s2_c[3];
   wire vpp = s2_c[4];
   wire p27 = s2_c[5];
   wire p26 = s2_c[6];
   wire p37 = s2_c[7];
   wire p36 = s2_c[8];
   wire in_mode = ~rst_pin_n & ~program_store_enable_n_n;
   wire strobe_fall = strb_d_ff & ~strobe_n;
   wire prog_ok = in_mode & vpp & p27;
   wire locked = o_sec1_ff | o_sec2_ff;
   wire wr_code = prog_ok & ~p26 & p37 & p36 & ~locked;
   wire wr_key = prog_ok & ~p26 & p37 & ~p36 & ~locked;
   wire wr_sec1 = prog_ok & p26 & p37 & p36;
   wire wr_sec2 = prog_ok & p26 & ~p37 & ~p36;
   wire rd_mode = in_mode & strobe_n & ea_hi & ~vpp & ~p27 & ~p26;
   wire rd_code = rd_mode & p37 & p36 & ~o_sec2_ff;
   wire rd_sig = rd_mode & ~p37 & ~p36;
   wire [4:0] key_idx = s2_addr[4:0];
   // Verify data: XNOR with key byte once any key entry is written
   wire [7:0] code_out = o_key_set_ff ? ~(mem[s2_addr] ^ key[key_idx]) : mem[s2_addr];
   wire [7:0] sig_out = (s2_addr == epv_pkg::SIG_MAKER_ADDR) ? epv_pkg::SIG_MAKER_VAL :
                        (s2_addr == epv_pkg::SIG_PART_ADDR) ? epv_pkg::SIG_PART_VAL :
                        epv_pkg::ERASED_BYTE;
   // Key array has no read path to port 0; only code_out uses it
   wire [7:0] nxt_dout = rd_sig ? sig_out : code_out;
   wire nxt_oe = rd_code | rd_sig;
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         s1_addr <= 13'h0000;
         s2_addr <= 13'h0000;
         s1_d <= 8'h00;
         s2_d <= 8'h00;
         s1_c <= 9'h1FF;
         s2_c <= 9'h1FF;
      end else begin
         s1_addr <= pins.addr;
         s2_addr <= s1_addr;
         s1_d <= pins.p0_in;
         s2_d <= s1_d;
         s1_c <= {pins.port3_bit6_select, pins.port3_bit7_select, pins.port2_bit6_select,
                  pins.port2_bit7_enable, pins.prog_supply_high,
                  pins.external_access_prog_supply, pins.latch_strobe_program_pulse_n,
                  pins.rst_n, pins.program_store_enable_n};
         s2_c <= s1_c;
      end
   end
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         strb_d_ff <= 1'b1;
         o_sec1_ff <= 1'b0;
         o_sec2_ff <= 1'b0;
         o_key_set_ff <= 1'b0;
         o_prog_mode_ff <= 1'b0;
         dout_ff <= 8'hFF;
         oe_ff <= 1'b0;
      end else begin
         strb_d_ff <= strobe_n;
         o_prog_mode_ff <= in_mode;
         dout_ff <= nxt_dout;
         oe_ff <= nxt_oe;
         if (strobe_fall && wr_sec1) o_sec1_ff <= 1'b1;
         if (strobe_fall && wr_sec2) o_sec2_ff <= 1'b1;
         if (strobe_fall && wr_key) o_key_set_ff <= 1'b1;
      end
   end
   // Array write: EPROM cells only clear bits, each pulse ANDs the byte in
   // Plain always, since the erased-state preload below writes the same arrays
   always @(posedge i_sys_clk) begin
      if (strobe_fall && wr_code) mem[s2_addr] <= mem[s2_addr] & s2_d;
      if (strobe_fall && wr_key) key[key_idx] <= key[key_idx] & s2_d;
   end
   // Erased array reads all ones
   initial begin
      for (int i = 0; i < epv_pkg::MEM_DEPTH; i++) mem[i] = epv_pkg::ERASED_BYTE;
      for (int j = 0; j < epv_pkg::KEY_DEPTH; j++) key[j] = epv_pkg::ERASED_BYTE;
   end
   assign pins.p0_dev_out = dout_ff;
   assign pins.p0_dev_oe = oe_ff;
endmodule : epv_device

// ### rtl/epv_host.sv
// Programmer end: drives mode pins and the 25-pulse program strobe, reads verify data
`timescale 1ns/1ps
//
// Summary of operation
// - Store enable high at power-up, low in reset
// - Device oscillator at 4 to 6 MHz
// - Address on ports 1, 2; data on port 0
// - Exactly 25 low strobe pulses per program
// - Pulse low 100 us, high at least 10 us
// - Key table programmed at locations 0 to 1FH
// - Any security bit blocks code and key programming
// - Other security bit stays programmable
// - Code readout only while security bit 2 clear
// - Verify drives addressed contents onto port 0
// - Encrypted verify byte is code XNOR key
// - Key table never readable
// - Signature read at 030H/031H, port 3 low
// - Program-code mode pin levels
// - Verify-code mode pin levels
// - Key-table mode: program levels, port3 bit6 low
// - Security-bit mode pin levels
// - Erased array reads all ones
module epv_host (
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   // Command side, buffered
   input wire logic i_cmd_valid,
   output logic o_cmd_ready,
   input wire epv_pkg::epv_op_t i_cmd_op,
   input wire logic [12:0] i_cmd_addr,
   input wire logic [7:0] i_cmd_data,
   // Result side
   output logic o_res_valid,
   input wire logic i_res_ready,
   output logic [7:0] o_res_data,
   output logic o_res_mismatch,
   // Pins
   epv_if.host pins
);
   typedef enum logic [2:0] {
      EPV_IDLE,
      EPV_SETUP,
      EPV_LOW,
      EPV_HIGH,
      EPV_HOLD,
      EPV_READ,
      EPV_DONE
   } epv_state_t;
   localparam int CW = 3 + 13 + 8;
   // Two-entry command buffer
   logic [CW-1:0] buf_ff [0:1];
   logic [1:0] cnt_ff;
   logic rd_ptr_ff, wr_ptr_ff;
   epv_state_t state_ff, nxt_state;
   logic [15:0] tmr_ff;
   logic [4:0] pulses_ff;
   logic [7:0] p0_s1_ff, p0_s2_ff;
   logic [CW-1:0] cur_ff;
   logic strobe_n_ff;
   // Two-entry result buffer: {mismatch, readback byte}
   logic [8:0] res_buf_ff [0:1];
   logic [1:0] res_cnt_ff;
   logic res_rd_ptr_ff;
   logic res_wr_ptr_ff;
   // Power-up: store enable high until the mode entry delay has run out
   logic [15:0] pwr_tmr_ff;
   logic mode_entered_ff;
   wire buf_full = cnt_ff == 2'h2;
   wire buf_empty = cnt_ff == 2'h0;
   wire res_full = res_cnt_ff == 2'h2;
   assign o_cmd_ready = ~buf_full;
   wire push = i_cmd_valid & ~buf_full;
   wire take = (state_ff == EPV_IDLE) & ~buf_empty & mode_entered_ff;
   wire [CW-1:0] head = buf_ff[rd_ptr_ff];
   wire epv_pkg::epv_op_t op = epv_pkg::epv_op_t'(cur_ff[CW-1 -: 3]);
   wire [12:0] c_addr = cur_ff[20:8];
   wire [7:0] c_data = cur_ff[7:0];
   wire is_prog = (op != epv_pkg::EPV_OP_VERIFY) && (op != epv_pkg::EPV_OP_SIGNATURE);
   wire tmr_done = tmr_ff == 16'h0000;
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         EPV_IDLE: if (take) nxt_state = EPV_SETUP;
         EPV_SETUP: if (tmr_done) nxt_state = is_prog ? EPV_LOW : EPV_READ;
         EPV_LOW: if (tmr_done) nxt_state = EPV_HIGH;
         EPV_HIGH: if (tmr_done) nxt_state = (pulses_ff == epv_pkg::PULSE_COUNT_M1) ?
                                             EPV_HOLD : EPV_LOW;
         EPV_HOLD: if (tmr_done) nxt_state = EPV_READ;
         EPV_READ: if (tmr_done) nxt_state = EPV_DONE;
         EPV_DONE: if (!res_full) nxt_state = EPV_IDLE;
         default: nxt_state = EPV_IDLE;
      endcase
   end
   wire [15:0] load_low = 16'(epv_pkg::PULSE_LOW_CYC - 1);
   wire [15:0] load_high = 16'(epv_pkg::PULSE_HIGH_CYC - 1);
   // Setup and hold sized for the device oscillator at its top rate
   wire [15:0] load_setup = 16'(epv_pkg::SETUP_CYC - 1);
   wire entering = nxt_state != state_ff;
   wire [15:0] nxt_tmr = !entering ? (tmr_done ? 16'h0000 : tmr_ff - 16'h0001) :
                         (nxt_state == EPV_LOW) ? load_low :
                         (nxt_state == EPV_HIGH) ? load_high : load_setup;
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cnt_ff <= 2'h0;
         rd_ptr_ff <= 1'b0;
         wr_ptr_ff <= 1'b0;
      end else begin
         if (push) wr_ptr_ff <= ~wr_ptr_ff;
         if (take) rd_ptr_ff <= ~rd_ptr_ff;
         cnt_ff <= cnt_ff + {1'b0, push} - {1'b0, take};
      end
   end
   always_ff @(posedge i_sys_clk) begin
      if (push) buf_ff[wr_ptr_ff] <= {i_cmd_op, i_cmd_addr, i_cmd_data};
   end
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_ff <= EPV_IDLE;
         tmr_ff <= 16'h0000;
         pulses_ff <= 5'h00;
         cur_ff <= '0;
         strobe_n_ff <= 1'b1;
      end else begin
         state_ff <= nxt_state;
         tmr_ff <= nxt_tmr;
         if (take) cur_ff <= head;
         if (take) pulses_ff <= 5'h00;
         else if (state_ff == EPV_HIGH && entering) pulses_ff <= pulses_ff + 5'h01;
         strobe_n_ff <= nxt_state != EPV_LOW;
      end
   end
   // Port 0 arrives from the device pins: two-stage synchroniser
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         p0_s1_ff <= 8'hFF;
         p0_s2_ff <= 8'hFF;
      end else begin
         p0_s1_ff <= pins.p0_in;
         p0_s2_ff <= p0_s1_ff;
      end
   end
   // Readback lands in the result buffer; DONE waits while it is full
   wire res_push = (state_ff == EPV_READ) && tmr_done;
   wire res_pop = (res_cnt_ff != 2'h0) && i_res_ready;
   wire nxt_res_mm = (op == epv_pkg::EPV_OP_PROG_CODE) && (p0_s2_ff != c_data);
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         res_cnt_ff <= 2'h0;
         res_rd_ptr_ff <= 1'b0;
         res_wr_ptr_ff <= 1'b0;
      end else begin
         if (res_push) res_wr_ptr_ff <= ~res_wr_ptr_ff;
         if (res_pop) res_rd_ptr_ff <= ~res_rd_ptr_ff;
         res_cnt_ff <= res_cnt_ff + {1'b0, res_push} - {1'b0, res_pop};
      end
   end
   always_ff @(posedge i_sys_clk) begin
      if (res_push) res_buf_ff[res_wr_ptr_ff] <= {nxt_res_mm, p0_s2_ff};
   end
   assign o_res_valid = res_cnt_ff != 2'h0;
   assign o_res_data = res_buf_ff[res_rd_ptr_ff][7:0];
   assign o_res_mismatch = res_buf_ff[res_rd_ptr_ff][8];
   // Store enable held high after power-up, then dropped while the reset pin stays low
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         pwr_tmr_ff <= 16'h0000;
         mode_entered_ff <= 1'b0;
      end else if (!mode_entered_ff) begin
         pwr_tmr_ff <= pwr_tmr_ff + 16'h0001;
         mode_entered_ff <= pwr_tmr_ff == load_setup;
      end
   end
   // Mode pin levels {port2 bit7, port2 bit6, port3 bit7, port3 bit6}
   function automatic logic [3:0] mode_levels(input epv_pkg::epv_op_t f_op, input logic f_prog);
      logic [3:0] lv;
      lv = 4'h3;
      if (f_op == epv_pkg::EPV_OP_SIGNATURE) begin
         lv = 4'h0;
      end else if (f_prog) begin
         case (f_op)
            epv_pkg::EPV_OP_PROG_CODE: lv = 4'hB;
            epv_pkg::EPV_OP_PROG_KEY: lv = 4'hA;
            epv_pkg::EPV_OP_PROG_SEC1: lv = 4'hF;
            epv_pkg::EPV_OP_PROG_SEC2: lv = 4'hC;
            default: lv = 4'h3;
         endcase
      end
      return lv;
   endfunction : mode_levels
   wire active = state_ff != EPV_IDLE && state_ff != EPV_DONE;
   wire reading = state_ff == EPV_READ;
   wire prog_phase = is_prog && !reading;
   wire prog_drive = active & prog_phase;
   wire [3:0] levels = mode_levels(op, prog_drive);
   // Reset pin held low throughout; store enable follows the power-up sequence
   assign pins.rst_n = 1'b0;
   assign pins.program_store_enable_n = ~mode_entered_ff;
   assign pins.latch_strobe_program_pulse_n = strobe_n_ff;
   assign pins.prog_supply_high = prog_drive;
   assign pins.external_access_prog_supply = 1'b1;
   assign pins.port2_bit7_enable = levels[3];
   assign pins.port2_bit6_select = levels[2];
   assign pins.port3_bit7_select = levels[1];
   assign pins.port3_bit6_select = levels[0];
   assign pins.addr = (op == epv_pkg::EPV_OP_PROG_KEY) ? {8'h00, c_addr[4:0]} : c_addr;
   assign pins.p0_host_out = c_data;
   assign pins.p0_host_oe = prog_drive;
endmodule : epv_host

// ### tb/epv_pins_assertions.sv
// Concurrent checks on the pins between programmer and device
`timescale 1ns/1ps
module epv_pins_assertions (
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   // Pins
   input wire logic latch_strobe_program_pulse_n,
   input wire logic prog_supply_high,
   input wire logic port2_bit7_enable,
   input wire logic port2_bit6_select,
   input wire logic port3_bit7_select,
   input wire logic port3_bit6_select,
   input wire logic [12:0] addr,
   input wire logic [7:0] p0_host_out,
   input wire logic [7:0] p0_dev_out,
   input wire logic p0_dev_oe
);
   logic [15:0] low_cnt_ff;
   logic [15:0] high_cnt_ff;
   logic [4:0] pulse_cnt_ff;
   logic strobe_q_ff;
   wire strobe_n = latch_strobe_program_pulse_n;
   wire strobe_fall = strobe_q_ff & ~strobe_n;
   wire [3:0] mode_bits = {port2_bit7_enable, port2_bit6_select, port3_bit7_select,
      port3_bit6_select};
   wire sig_pins = p0_dev_oe & ~port3_bit7_select & ~port3_bit6_select;
   wire [15:0] nxt_low_cnt = strobe_n ? 16'h0000 : low_cnt_ff + 16'h0001;
   // High time saturates so the first pulse of a sequence always qualifies
   wire [15:0] nxt_high_cnt = !strobe_n ? 16'h0000 :
      (high_cnt_ff[12] ? high_cnt_ff : high_cnt_ff + 16'h0001);
   wire [4:0] nxt_pulse_cnt = !prog_supply_high ? 5'h00 : pulse_cnt_ff + {4'h0, strobe_fall};
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_rst_n);
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         low_cnt_ff <= 16'h0000;
         high_cnt_ff <= 16'h1000;
         pulse_cnt_ff <= 5'h00;
         strobe_q_ff <= 1'b1;
      end else begin
         low_cnt_ff <= nxt_low_cnt;
         high_cnt_ff <= nxt_high_cnt;
         pulse_cnt_ff <= nxt_pulse_cnt;
         strobe_q_ff <= strobe_n;
      end
   end
   chk_pulse_low_width: assert property ($rose(strobe_n) |->
      low_cnt_ff >= 16'h0708 && low_cnt_ff <= 16'h0898) else $error("strobe low width off");
   chk_pulse_high_gap: assert property (strobe_fall |-> high_cnt_ff >= 16'h00C8)
      else $error("strobe high gap too short");
   chk_pulse_count_total: assert property ($fell(prog_supply_high) |-> pulse_cnt_ff == 5'h19)
      else $error("pulse count per program wrong");
   chk_strobe_needs_supply: assert property (!strobe_n |-> prog_supply_high && port2_bit7_enable)
      else $error("strobe low without programming levels");
   chk_prog_mode_levels: assert property (strobe_fall |->
      mode_bits inside {4'hB, 4'hA, 4'hF, 4'hC}) else $error("illegal program mode levels");
   chk_no_drive_pulse: assert property (!strobe_n |-> !p0_dev_oe)
      else $error("device drives port 0 during a pulse");
   chk_addr_data_held: assert property (!strobe_n |-> $stable(addr) && $stable(p0_host_out))
      else $error("address or data moved during a pulse");
   chk_sig_maker_byte: assert property ((sig_pins && addr == epv_pkg::SIG_MAKER_ADDR)[*6]
      |-> p0_dev_out == epv_pkg::SIG_MAKER_VAL) else $error("maker byte wrong");
   chk_sig_part_byte: assert property ((sig_pins && addr == epv_pkg::SIG_PART_ADDR)[*6]
      |-> p0_dev_out == epv_pkg::SIG_PART_VAL) else $error("part byte wrong");
endmodule : epv_pins_assertions

// ### tb/test_eprom_program_verify_port.sv
// Self-checking bench joining the programmer and device ends
`timescale 1ns/1ps
module test_eprom_program_verify_port;
   logic i_sys_clk = 1'b0;
   logic i_rst_n = 1'b0;
   logic i_cmd_valid = 1'b0;
   logic o_cmd_ready;
   epv_pkg::epv_op_t i_cmd_op = epv_pkg::EPV_OP_VERIFY;
   logic [12:0] i_cmd_addr = 13'h0000;
   logic [7:0] i_cmd_data = 8'h00;
   logic o_res_valid;
   logic i_res_ready = 1'b0;
   logic [7:0] o_res_data;
   logic o_res_mismatch;
   logic o_sec1_ff;
   logic o_sec2_ff;
   logic o_key_set_ff;
   logic o_prog_mode_ff;
   int fail_count = 0;
   int n_checks = 0;
   epv_if bus ();
   always #25 i_sys_clk = ~i_sys_clk;
   epv_device epv_device_inst (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .pins(bus),
      .o_sec1_ff(o_sec1_ff), .o_sec2_ff(o_sec2_ff), .o_key_set_ff(o_key_set_ff),
      .o_prog_mode_ff(o_prog_mode_ff));
   epv_host epv_host_inst (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_cmd_valid(i_cmd_valid),
      .o_cmd_ready(o_cmd_ready), .i_cmd_op(i_cmd_op), .i_cmd_addr(i_cmd_addr),
      .i_cmd_data(i_cmd_data), .o_res_valid(o_res_valid), .i_res_ready(i_res_ready),
      .o_res_data(o_res_data), .o_res_mismatch(o_res_mismatch), .pins(bus));
   epv_pins_assertions epv_pins_assertions_inst (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
      .latch_strobe_program_pulse_n(bus.latch_strobe_program_pulse_n),
      .prog_supply_high(bus.prog_supply_high), .port2_bit7_enable(bus.port2_bit7_enable),
      .port2_bit6_select(bus.port2_bit6_select), .port3_bit7_select(bus.port3_bit7_select),
      .port3_bit6_select(bus.port3_bit6_select), .addr(bus.addr),
      .p0_host_out(bus.p0_host_out), .p0_dev_out(bus.p0_dev_out), .p0_dev_oe(bus.p0_dev_oe));
   task automatic print_verdict;
      $display("Checks %0d, errors %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : print_verdict
   task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check_byte
   task automatic check_bit(input logic got, input logic exp);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check_bit
   // An array with security bit 2 set floats port 0, which the pull-up reads as all ones
   function automatic logic [7:0] exp_verify(input logic locked, input logic [7:0] stored);
      return locked ? epv_pkg::ERASED_BYTE : stored;
   endfunction : exp_verify
   task automatic cmd_send(input epv_pkg::epv_op_t op, input logic [12:0] a, input logic [7:0] d);
      int i;
      i_cmd_op = op;
      i_cmd_addr = a;
      i_cmd_data = d;
      i_cmd_valid = 1'b1;
      for (i = 0; i < 100 && o_cmd_ready !== 1'b1; i++) @(negedge i_sys_clk);
      if (i == 100) check_bit(1'b0, 1'b1);
      if (i == 100) print_verdict();
      @(negedge i_sys_clk);
   endtask : cmd_send
   task automatic res_get(output logic [7:0] d, output logic mm);
      int i;
      for (i = 0; i < 60000 && o_res_valid !== 1'b1; i++) @(negedge i_sys_clk);
      if (i == 60000) check_bit(1'b0, 1'b1);
      if (i == 60000) print_verdict();
      // Receiver stalls a while before taking the result
      repeat ($urandom_range(0, 20)) @(negedge i_sys_clk);
      d = o_res_data;
      mm = o_res_mismatch;
      i_res_ready = 1'b1;
      @(negedge i_sys_clk);
      i_res_ready = 1'b0;
   endtask : res_get
   initial begin
      logic [7:0] rd;
      logic mm;
      logic [12:0] a_code;
      logic [7:0] d_code;
      int k;
      k = $urandom(45);
      repeat (4) @(negedge i_sys_clk);
      i_rst_n = 1'b1;
      a_code = 13'($urandom_range(8191, 64));
      d_code = 8'($urandom);
      for (k = 0; k < 2; k++) begin
         // Two commands queued back to back
         cmd_send(epv_pkg::EPV_OP_VERIFY, 13'($urandom_range(8191, 64)), 8'h00);
         cmd_send(epv_pkg::EPV_OP_SIGNATURE, 13'h0030 + 13'(k), 8'h00);
         i_cmd_valid = 1'b0;
         res_get(rd, mm);
         check_byte(rd, epv_pkg::ERASED_BYTE);
         res_get(rd, mm);
         check_byte(rd, (k == 0) ? epv_pkg::SIG_MAKER_VAL : epv_pkg::SIG_PART_VAL);
      end
      check_bit(o_prog_mode_ff, 1'b1);
      cmd_send(epv_pkg::EPV_OP_PROG_CODE, a_code, d_code);
      i_cmd_valid = 1'b0;
      res_get(rd, mm);
      check_byte(rd, d_code);
      check_bit(mm, 1'b0);
      cmd_send(epv_pkg::EPV_OP_VERIFY, a_code, 8'h00);
      i_cmd_valid = 1'b0;
      res_get(rd, mm);
      check_byte(rd, exp_verify(1'b0, d_code));
      check_bit(o_key_set_ff, 1'b0);
      cmd_send(epv_pkg::EPV_OP_PROG_SEC2, 13'h0000, 8'h00);
      i_cmd_valid = 1'b0;
      res_get(rd, mm);
      check_byte(rd, exp_verify(1'b1, 8'h00));
      check_bit(o_sec2_ff, 1'b1);
      check_bit(o_sec1_ff, 1'b0);
      cmd_send(epv_pkg::EPV_OP_VERIFY, a_code, 8'h00);
      i_cmd_valid = 1'b0;
      res_get(rd, mm);
      check_byte(rd, exp_verify(1'b1, d_code));
      print_verdict();
   end
endmodule : test_eprom_program_verify_port
